// ===== hdl/pcidcr_pkg.sv
// Constants for the device control and device status registers
package pcidcr_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] DEV_CTRL_OFFSET = 8'h78;
    localparam logic [7:0] DEV_STAT_OFFSET = 8'h7A;
    localparam logic [15:0] DEV_CTRL_RESET = 16'h2000;
    localparam logic [15:0] DEV_STAT_RESET = 16'h0000;
    // Writable bits: 15, 14:12, 10, 7:5, 3:0
    localparam logic [15:0] DEV_CTRL_RW_MASK = 16'hF4EF;

    // ----------------------------------------------------------------
    // Device control fields
    // ----------------------------------------------------------------
    localparam int CFG_RETRY_BIT = 15;
    localparam int RD_SIZE_MSB = 14;
    localparam int RD_SIZE_LSB = 12;
    localparam int NO_SNOOP_BIT = 11;
    localparam int AUX_PM_BIT = 10;
    localparam int PHANTOM_BIT = 9;
    localparam int EXT_TAG_BIT = 8;
    localparam int PAY_SIZE_MSB = 7;
    localparam int PAY_SIZE_LSB = 5;
    localparam int RELAXED_BIT = 4;
    localparam int UR_REP_BIT = 3;
    localparam int FATAL_REP_BIT = 2;
    localparam int NONFATAL_REP_BIT = 1;
    localparam int COR_REP_BIT = 0;

    // ----------------------------------------------------------------
    // Device status fields, also the error event index
    // ----------------------------------------------------------------
    localparam int ERR_NUM = 4;
    localparam int UR_IDX = 3;
    localparam int FATAL_IDX = 2;
    localparam int NONFATAL_IDX = 1;
    localparam int COR_IDX = 0;
    // Status half sits in byte lanes 2 and 3 of the word at 78h
    localparam int STAT_WORD_LSB = 16;

    // ----------------------------------------------------------------
    // Size encoding
    // ----------------------------------------------------------------
    localparam int LEN_W = 13;
    localparam logic [2:0] SIZE_CODE_MAX = 3'h5;
    localparam logic [12:0] SIZE_BASE_BYTES = 13'h0080;
    localparam logic [2:0] RD_SIZE_RESET_CODE = 3'h2;
    localparam logic [2:0] PAY_SIZE_RESET_CODE = 3'h0;
    localparam logic [12:0] RD_SIZE_RESET_BYTES = 13'h0200;
    localparam logic [12:0] PAY_SIZE_RESET_BYTES = 13'h0080;

endpackage

// ===== hdl/pcidcr_err_if.sv
// Error event, report enable and status signals between top and reporter
interface pcidcr_err_if;
    logic [3:0] event_hit;
    logic [3:0] report_en;
    logic [3:0] clear;
    logic [3:0] status;
    logic msg_fatal;
    logic msg_nonfatal;
    logic msg_cor;

    modport ctrl (
        output event_hit,
        output report_en,
        output clear,
        input status,
        input msg_fatal,
        input msg_nonfatal,
        input msg_cor
    );

    modport rep (
        input event_hit,
        input report_en,
        input clear,
        output status,
        output msg_fatal,
        output msg_nonfatal,
        output msg_cor
    );
endinterface

// ===== hdl/pcidcr_size_clamp.sv
// Size code decoder and request length limiter
module pcidcr_size_clamp (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] size_code,
    input wire logic [12:0] req_len,
    output logic [12:0] limit,
    output logic [12:0] grant_len
);

    // Reserved codes fall back to the smallest size
    wire code_ok = size_code <= pcidcr_pkg::SIZE_CODE_MAX;
    wire [12:0] limit_dec = code_ok ? 13'(pcidcr_pkg::SIZE_BASE_BYTES << size_code)
                                    : pcidcr_pkg::SIZE_BASE_BYTES;
    wire [12:0] grant_dec = (req_len > limit_dec) ? limit_dec : req_len;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            limit <= pcidcr_pkg::SIZE_BASE_BYTES;
            grant_len <= 13'h0000;
        end else begin
            limit <= limit_dec;
            grant_len <= grant_dec;
        end
    end

endmodule

// ===== hdl/pcidcr_err_report.sv
// Sticky error status flags and gated error message requests
module pcidcr_err_report (
    input wire logic clk,
    input wire logic rst,
    pcidcr_err_if.rep err
);

    localparam int UR = pcidcr_pkg::UR_IDX;
    localparam int FE = pcidcr_pkg::FATAL_IDX;
    localparam int NF = pcidcr_pkg::NONFATAL_IDX;
    localparam int CE = pcidcr_pkg::COR_IDX;

    // Unsupported requests travel as nonfatal messages
    wire next_fatal = err.event_hit[FE] & err.report_en[FE];
    wire next_nonfatal = (err.event_hit[NF] & err.report_en[NF])
                       | (err.event_hit[UR] & err.report_en[UR]);
    wire next_cor = err.event_hit[CE] & err.report_en[CE];

    // Set wins over a clear in the same cycle
    wire [pcidcr_pkg::ERR_NUM-1:0] next_status;
    genvar i;
    generate
        for (i = 0; i < pcidcr_pkg::ERR_NUM; i++) begin : g_flag
            assign next_status[i] = err.event_hit[i] | (err.status[i] & ~err.clear[i]);
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err.status <= pcidcr_pkg::DEV_STAT_RESET[pcidcr_pkg::ERR_NUM-1:0];
        end else begin
            err.status <= next_status;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err.msg_fatal <= 1'b0;
            err.msg_nonfatal <= 1'b0;
            err.msg_cor <= 1'b0;
        end else begin
            err.msg_fatal <= next_fatal;
            err.msg_nonfatal <= next_nonfatal;
            err.msg_cor <= next_cor;
        end
    end

endmodule

// ===== hdl/pcidcr_device_control.sv
// Device control register with its status flags, size limits and error gating

module pcidcr_device_control (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [3:0] CFG_BE,
    input wire logic [31:0] CFG_WDATA,
    output logic [31:0] CFG_RDATA,
    output logic CFG_RD_VALID,
    input wire logic UR_RECEIVED,
    input wire logic FATAL_EVENT,
    input wire logic NONFATAL_EVENT,
    input wire logic COR_EVENT,
    output logic MSG_ERR_FATAL,
    output logic MSG_ERR_NONFATAL,
    output logic MSG_ERR_COR,
    input wire logic CFG_FWD_TIMEOUT,
    output logic CPL_CFG_RETRY,
    input wire logic [12:0] READ_REQ_LEN,
    output logic [12:0] READ_GRANT_LEN,
    output logic [12:0] READ_LIMIT,
    input wire logic [12:0] PAYLOAD_REQ_LEN,
    output logic [12:0] PAYLOAD_GRANT_LEN,
    output logic [12:0] PAYLOAD_LIMIT,
    output logic NO_SNOOP_ATTR
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [15:0] dev_control;
    logic [31:0] rdata;
    logic rd_valid;
    logic retry;
    logic no_snoop;

    pcidcr_err_if err_bus ();

    // ----------------------------------------------------------------
    // Configuration access decode
    // ----------------------------------------------------------------
    wire ctrl_hit = CFG_ADDR[7:2] == pcidcr_pkg::DEV_CTRL_OFFSET[7:2];
    wire ctrl_wr = CFG_WR & ctrl_hit;
    wire ctrl_rd = CFG_RD & ctrl_hit;
    wire [15:0] lane_mask = {{8{CFG_BE[1]}}, {8{CFG_BE[0]}}};
    wire [15:0] wr_mask = lane_mask & pcidcr_pkg::DEV_CTRL_RW_MASK;
    wire [15:0] next_dev_control = ctrl_wr
        ? ((dev_control & ~wr_mask) | (CFG_WDATA[15:0] & wr_mask))
        : dev_control;
    wire stat_wr = ctrl_wr & CFG_BE[2];
    wire [3:0] stat_clear = stat_wr
        ? CFG_WDATA[pcidcr_pkg::STAT_WORD_LSB +: pcidcr_pkg::ERR_NUM]
        : 4'h0;
    wire [15:0] dev_status = {12'h000, err_bus.status};
    wire [31:0] next_rdata = ctrl_rd ? {dev_status, dev_control} : 32'h0000_0000;

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    wire retry_en = dev_control[pcidcr_pkg::CFG_RETRY_BIT];
    wire [2:0] read_size_code = dev_control[pcidcr_pkg::RD_SIZE_MSB:pcidcr_pkg::RD_SIZE_LSB];
    wire [2:0] pay_size_code = dev_control[pcidcr_pkg::PAY_SIZE_MSB:pcidcr_pkg::PAY_SIZE_LSB];
    wire next_retry = CFG_FWD_TIMEOUT & retry_en;

    assign err_bus.event_hit = {UR_RECEIVED, FATAL_EVENT, NONFATAL_EVENT, COR_EVENT};
    assign err_bus.report_en = dev_control[pcidcr_pkg::UR_REP_BIT:pcidcr_pkg::COR_REP_BIT];
    assign err_bus.clear = stat_clear;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            dev_control <= pcidcr_pkg::DEV_CTRL_RESET;
        end else begin
            dev_control <= next_dev_control;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rdata <= 32'h0000_0000;
            rd_valid <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rd_valid <= CFG_RD;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            retry <= 1'b0;
            no_snoop <= 1'b0;
        end else begin
            retry <= next_retry;
            no_snoop <= 1'b0;
        end
    end

    assign CFG_RDATA = rdata;
    assign CFG_RD_VALID = rd_valid;
    assign CPL_CFG_RETRY = retry;
    assign NO_SNOOP_ATTR = no_snoop;
    assign MSG_ERR_FATAL = err_bus.msg_fatal;
    assign MSG_ERR_NONFATAL = err_bus.msg_nonfatal;
    assign MSG_ERR_COR = err_bus.msg_cor;

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    pcidcr_size_clamp u_read_clamp (
        .clk(CLK_SYS),
        .rst(RST),
        .size_code(read_size_code),
        .req_len(READ_REQ_LEN),
        .limit(READ_LIMIT),
        .grant_len(READ_GRANT_LEN)
    );

    pcidcr_size_clamp u_payload_clamp (
        .clk(CLK_SYS),
        .rst(RST),
        .size_code(pay_size_code),
        .req_len(PAYLOAD_REQ_LEN),
        .limit(PAYLOAD_LIMIT),
        .grant_len(PAYLOAD_GRANT_LEN)
    );

    pcidcr_err_report u_err_report (
        .clk(CLK_SYS),
        .rst(RST),
        .err(err_bus.rep)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    AST_READ_RETURNS_CONTROL: assert property (
        ctrl_rd |=> CFG_RD_VALID && CFG_RDATA[15:0] == $past(dev_control)
    ) else $error("control read returned wrong data");

    AST_RETRY_ON_TIMEOUT: assert property (
        CFG_FWD_TIMEOUT && retry_en |=> CPL_CFG_RETRY
    ) else $error("retry completion missing after time-out");

    AST_NO_RETRY_DISABLED: assert property (
        !retry_en && !ctrl_wr |=> !CPL_CFG_RETRY
    ) else $error("retry completion while retry disabled");

    AST_READ_LIMIT_CODE: assert property (
        (!RST && read_size_code == pcidcr_pkg::RD_SIZE_RESET_CODE) [*2]
        |-> READ_LIMIT == pcidcr_pkg::RD_SIZE_RESET_BYTES
    ) else $error("read limit does not match its code");

    AST_READ_GRANT_CAPPED: assert property (
        READ_GRANT_LEN <= READ_LIMIT
    ) else $error("read request exceeds limit");

    AST_PAYLOAD_CAPPED: assert property (
        ((!RST && pay_size_code == pcidcr_pkg::PAY_SIZE_RESET_CODE) [*2]
         |-> PAYLOAD_LIMIT == pcidcr_pkg::PAY_SIZE_RESET_BYTES)
        and (PAYLOAD_GRANT_LEN <= PAYLOAD_LIMIT)
    ) else $error("payload exceeds limit");

    AST_NO_SNOOP_ZERO: assert property (
        !NO_SNOOP_ATTR && !dev_control[pcidcr_pkg::NO_SNOOP_BIT]
    ) else $error("no snoop seen set");

    AST_AUX_PM_WRITE: assert property (
        ctrl_wr && CFG_BE[1]
        |=> dev_control[pcidcr_pkg::AUX_PM_BIT] == $past(CFG_WDATA[pcidcr_pkg::AUX_PM_BIT])
    ) else $error("aux power bit did not take the write");

    AST_UNSUPPORTED_ZERO: assert property (
        !dev_control[pcidcr_pkg::PHANTOM_BIT] && !dev_control[pcidcr_pkg::EXT_TAG_BIT]
        && !dev_control[pcidcr_pkg::RELAXED_BIT]
    ) else $error("unsupported enable reads as one");

    AST_UR_REPORT: assert property (
        UR_RECEIVED && dev_control[pcidcr_pkg::UR_REP_BIT] |=> MSG_ERR_NONFATAL
    ) else $error("unsupported request not reported");

    AST_FATAL_GATED: assert property (
        MSG_ERR_FATAL |-> $past(FATAL_EVENT) && $past(dev_control[pcidcr_pkg::FATAL_REP_BIT])
    ) else $error("fatal message without enabled event");

    AST_NONFATAL_GATED: assert property (
        MSG_ERR_NONFATAL
        |-> $past(NONFATAL_EVENT && dev_control[pcidcr_pkg::NONFATAL_REP_BIT]
                  || UR_RECEIVED && dev_control[pcidcr_pkg::UR_REP_BIT])
    ) else $error("nonfatal message without enabled event");

    AST_COR_REPORT: assert property (
        COR_EVENT |=> MSG_ERR_COR == $past(dev_control[pcidcr_pkg::COR_REP_BIT])
    ) else $error("correctable message gating wrong");

    AST_UR_DETECTED: assert property (
        UR_RECEIVED |=> err_bus.status[pcidcr_pkg::UR_IDX] [*1] ##1
            (err_bus.status[pcidcr_pkg::UR_IDX] || $past(stat_clear[pcidcr_pkg::UR_IDX]))
    ) else $error("unsupported request flag not set");

    AST_READ_ONLY_FIXED: assert property (
        ctrl_wr |=> (dev_control & ~pcidcr_pkg::DEV_CTRL_RW_MASK)
                    == (pcidcr_pkg::DEV_CTRL_RESET & ~pcidcr_pkg::DEV_CTRL_RW_MASK)
    ) else $error("write changed a read-only bit");

    AST_CONTROL_HOLDS: assert property (
        !ctrl_wr |=> dev_control == $past(dev_control)
    ) else $error("control changed without a write");

    AST_MISS_WRITE_IGNORED: assert property (
        CFG_WR && !ctrl_hit |=> dev_control == $past(dev_control)
    ) else $error("write to another offset changed control");

    AST_MISS_READS_ZERO: assert property (
        CFG_RD && !ctrl_hit |=> CFG_RD_VALID && CFG_RDATA == 32'h0000_0000
    ) else $error("read of another offset returned data");

    AST_RDATA_IDLE: assert property (
        !CFG_RD |=> !CFG_RD_VALID && CFG_RDATA == 32'h0000_0000
    ) else $error("read data shown without a read");

    AST_RETRY_NEEDS_TIMEOUT: assert property (
        CPL_CFG_RETRY |-> $past(CFG_FWD_TIMEOUT) && $past(retry_en)
    ) else $error("retry completion without an enabled time-out");

    AST_READ_LIMIT_RESERVED: assert property (
        (!RST && read_size_code > pcidcr_pkg::SIZE_CODE_MAX) [*2]
        |-> READ_LIMIT == pcidcr_pkg::SIZE_BASE_BYTES
    ) else $error("reserved read size code gave a wrong limit");

    AST_READ_LIMIT_TOP: assert property (
        (!RST && read_size_code == pcidcr_pkg::SIZE_CODE_MAX) [*2]
        |-> READ_LIMIT == 13'(pcidcr_pkg::SIZE_BASE_BYTES << pcidcr_pkg::SIZE_CODE_MAX)
    ) else $error("largest read size code gave a wrong limit");

    AST_READ_GRANT_PASSES: assert property (
        !RST && READ_REQ_LEN <= pcidcr_pkg::SIZE_BASE_BYTES
        |=> READ_GRANT_LEN == $past(READ_REQ_LEN)
    ) else $error("short read request was cut");

    AST_READ_GRANT_CUT: assert property (
        !RST && READ_REQ_LEN > 13'(pcidcr_pkg::SIZE_BASE_BYTES << pcidcr_pkg::SIZE_CODE_MAX)
        |=> READ_GRANT_LEN == READ_LIMIT
    ) else $error("long read request not cut to the limit");

    AST_PAY_LIMIT_RESERVED: assert property (
        (!RST && pay_size_code > pcidcr_pkg::SIZE_CODE_MAX) [*2]
        |-> PAYLOAD_LIMIT == pcidcr_pkg::SIZE_BASE_BYTES
    ) else $error("reserved payload size code gave a wrong limit");

    AST_PAY_LIMIT_TOP: assert property (
        (!RST && pay_size_code == pcidcr_pkg::SIZE_CODE_MAX) [*2]
        |-> PAYLOAD_LIMIT == 13'(pcidcr_pkg::SIZE_BASE_BYTES << pcidcr_pkg::SIZE_CODE_MAX)
    ) else $error("largest payload size code gave a wrong limit");

    AST_PAY_GRANT_PASSES: assert property (
        !RST && PAYLOAD_REQ_LEN <= pcidcr_pkg::SIZE_BASE_BYTES
        |=> PAYLOAD_GRANT_LEN == $past(PAYLOAD_REQ_LEN)
    ) else $error("short payload was cut");

    AST_PAY_GRANT_CUT: assert property (
        !RST && PAYLOAD_REQ_LEN > 13'(pcidcr_pkg::SIZE_BASE_BYTES << pcidcr_pkg::SIZE_CODE_MAX)
        |=> PAYLOAD_GRANT_LEN == PAYLOAD_LIMIT
    ) else $error("long payload not cut to the limit");

    AST_UR_SILENT: assert property (
        UR_RECEIVED && !dev_control[pcidcr_pkg::UR_REP_BIT]
        && !(NONFATAL_EVENT && dev_control[pcidcr_pkg::NONFATAL_REP_BIT])
        |=> !MSG_ERR_NONFATAL
    ) else $error("unsupported request reported while disabled");

    AST_FATAL_REPORT: assert property (
        FATAL_EVENT && dev_control[pcidcr_pkg::FATAL_REP_BIT] |=> MSG_ERR_FATAL
    ) else $error("enabled fatal event not reported");

    AST_NONFATAL_REPORT: assert property (
        NONFATAL_EVENT && dev_control[pcidcr_pkg::NONFATAL_REP_BIT] |=> MSG_ERR_NONFATAL
    ) else $error("enabled nonfatal event not reported");

    AST_COR_GATED: assert property (
        MSG_ERR_COR |-> $past(COR_EVENT) && $past(dev_control[pcidcr_pkg::COR_REP_BIT])
    ) else $error("correctable message without enabled event");

    AST_STATUS_STICKY: assert property (
        err_bus.status[pcidcr_pkg::UR_IDX] && !stat_clear[pcidcr_pkg::UR_IDX]
        |=> err_bus.status[pcidcr_pkg::UR_IDX]
    ) else $error("unsupported request flag lost without a clear");

    AST_STATUS_READ: assert property (
        ctrl_rd |=> CFG_RDATA[31:16] == {12'h000, $past(err_bus.status)}
    ) else $error("status read returned wrong data");

endmodule

// ===== verification/pcidcr_rc_model.sv
// Root complex side model that counts error messages and retry completions
module pcidcr_rc_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic msg_fatal,
    input wire logic msg_nonfatal,
    input wire logic msg_cor,
    input wire logic cpl_retry,
    output logic [7:0] n_fat,
    output logic [7:0] n_nf,
    output logic [7:0] n_cor,
    output logic [7:0] n_rty
);
    timeunit 1ns;
    timeprecision 1ps;
    // Each pulse is one message or completion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            n_fat <= 8'h00;
            n_nf <= 8'h00;
            n_cor <= 8'h00;
            n_rty <= 8'h00;
        end else begin
            n_fat <= n_fat + 8'(msg_fatal);
            n_nf <= n_nf + 8'(msg_nonfatal);
            n_cor <= n_cor + 8'(msg_cor);
            n_rty <= n_rty + 8'(cpl_retry);
        end
    end
endmodule

// ===== verification/tb_pcie_device_control_register.sv
// Self-checking bench for the device control register block
module tb_pcie_device_control_register;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h78;
    logic [3:0] be = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic rvalid;
    logic [4:0] ev = 5'h00;
    logic m_f, m_nf, m_c, rty, nsa;
    logic [12:0] rq = 13'h1FFF;
    logic [12:0] pq = 13'h1FFF;
    logic [12:0] rg, rl, pg, pl;
    logic [7:0] n_fat, n_nf, n_cor, n_rty;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [3:0] got;

    always #4 clk = ~clk;

    pcidcr_device_control dut_u (.CLK_SYS(clk), .RST(rst), .CFG_WR(wr), .CFG_RD(rd),
        .CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wdata), .CFG_RDATA(rdata),
        .CFG_RD_VALID(rvalid), .UR_RECEIVED(ev[3]), .FATAL_EVENT(ev[2]),
        .NONFATAL_EVENT(ev[1]), .COR_EVENT(ev[0]), .MSG_ERR_FATAL(m_f),
        .MSG_ERR_NONFATAL(m_nf), .MSG_ERR_COR(m_c), .CFG_FWD_TIMEOUT(ev[4]),
        .CPL_CFG_RETRY(rty), .READ_REQ_LEN(rq), .READ_GRANT_LEN(rg), .READ_LIMIT(rl),
        .PAYLOAD_REQ_LEN(pq), .PAYLOAD_GRANT_LEN(pg), .PAYLOAD_LIMIT(pl),
        .NO_SNOOP_ATTR(nsa));

    pcidcr_rc_model rc_u (.clk(clk), .rst(rst), .msg_fatal(m_f), .msg_nonfatal(m_nf),
        .msg_cor(m_c), .cpl_retry(rty), .n_fat(n_fat), .n_nf(n_nf), .n_cor(n_cor),
        .n_rty(n_rty));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        be <= b;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(32'(rvalid), 32'h1);
        check(rdata, exp);
    endtask

    // Pulse one event line, capture {fatal, nonfatal, cor, retry} a cycle later
    task automatic pulse(input int i);
        @(posedge clk);
        ev <= 5'h01 << i;
        @(posedge clk);
        ev <= 5'h00;
        #1;
        got = {m_f, m_nf, m_c, rty};
    endtask

    function automatic logic [12:0] lim(input int c);
        return (c > 5) ? 13'h0080 : 13'h0080 << c;
    endfunction

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        cfg_rd(8'h78, 32'h0000_2000);
        check(32'(rl), 32'h0200);
        check(32'(pl), 32'h0080);
        cfg_rd(8'h40, 32'h0);
    endtask

    task automatic t_access();
        cfg_wr(8'h78, 4'h3, 32'h0000_FFFF);
        cfg_rd(8'h78, 32'h0000_F4EF);
        cfg_wr(8'h78, 4'h1, 32'h0000_0000);
        cfg_rd(8'h78, 32'h0000_F400);
        cfg_wr(8'h40, 4'h3, 32'h0000_0000);
        cfg_rd(8'h78, 32'h0000_F400);
        check(32'(nsa), 32'h0);
    endtask

    task automatic t_sizes();
        for (int c = 0; c < 8; c++) begin
            cfg_wr(8'h78, 4'h3, {16'h0, 1'b0, 3'(c), 4'h0, 3'(c), 5'h00});
            repeat (2) @(posedge clk);
            #1;
            check(32'(rl), 32'(lim(c)));
            check(32'(rg), 32'(lim(c)));
            check(32'(pl), 32'(lim(c)));
            check(32'(pg), 32'(lim(c)));
        end
        @(posedge clk);
        rq <= 13'h0064;
        pq <= 13'h007F;
        repeat (2) @(posedge clk);
        #1;
        check(32'(rg), 32'h0064);
        check(32'(pg), 32'h007F);
    endtask

    task automatic t_errors();
        cfg_wr(8'h78, 4'h3, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            pulse(i);
            check(32'(got), 32'h0);
        end
        cfg_rd(8'h78, 32'h000F_0000);
        cfg_wr(8'h78, 4'h4, 32'h000F_0000);
        cfg_rd(8'h78, 32'h0);
        cfg_wr(8'h78, 4'h3, 32'h0000_0008);
        pulse(1);
        check(32'(got), 32'h0);
        pulse(3);
        check(32'(got), 32'h4);
        cfg_wr(8'h78, 4'h3, 32'h0000_800F);
        for (int i = 0; i < 5; i++) begin
            pulse(i);
            check(32'(got), 32'({i == 2, i == 1 || i == 3, i == 0, i == 4}));
        end
        cfg_rd(8'h78, 32'h000F_800F);
        check(32'({n_fat, n_nf, n_cor, n_rty}), 32'h01_03_01_01);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            summarize();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_access();
        t_sizes();
        t_errors();
        summarize();
    end
endmodule
